// [rpm_pkg.sv]
// Constants, encodings and register layout for the retimer power mode control block.
// Assumes one 10 MHz clock in every user and a synchronous active-high reset in rpm_top.
package rpm_pkg;

    // ************************************************************
    // Clock and bus identity
    // ************************************************************
    localparam int CLK_MHZ = 10;
    localparam logic [6:0] BUS_ADDR = 7'h2c; // Arbitrary neutral bus address.

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] OFS_POWER_DOWN = 8'h09;
    localparam logic [7:0] OFS_STATUS = 8'h0a;
    localparam logic [7:0] OFS_TERM_SLEW = 8'h0b;
    localparam logic [7:0] OFS_SWING_EMPH = 8'h0c;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] RST_POWER_DOWN = 8'h00;
    localparam logic [7:0] RST_TERM_SLEW = 8'h00;
    localparam logic [7:0] RST_SWING_EMPH = 8'h00;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int PD_REG_CTRL_BIT = 0;
    localparam int PD_LANE_SWAP_BIT = 1;
    localparam int PD_SOFT_PD_BIT = 3;
    localparam int ST_NORMAL_BIT = 0;
    localparam int ST_RATIO_BIT = 1;
    localparam int ST_RETIMER_BIT = 2;
    localparam int TS_TERM_LSB = 3;
    localparam int TS_SLEW_LSB = 6;
    localparam int SE_EMPH_LSB = 0;
    localparam int SE_SWING_LSB = 2;

    // ************************************************************
    // Strap pins and their three-level codes
    // ************************************************************
    localparam int NUM_STRAPS = 4;
    localparam int STRAP_EMPH = 0;
    localparam int STRAP_TERM = 1;
    localparam int STRAP_SLEW = 2;
    localparam int STRAP_EQ = 3;
    localparam logic [1:0] LVL_LOW = 2'h0;
    localparam logic [1:0] LVL_MID = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;
    localparam logic [1:0] EMPH_0DB = 2'h0;
    localparam logic [1:0] EMPH_M2DB = 2'h1;
    localparam logic [1:0] EMPH_HIGH = 2'h2;
    localparam logic [1:0] SLEW_STRAP_MID = 2'h2;

    // ************************************************************
    // Power states and bus phases
    // ************************************************************
    typedef enum logic [3:0] {
        PS_OFF = 4'h1,
        PS_NO_HPD = 4'h2,
        PS_SOFT = 4'h4,
        PS_NORMAL = 4'h8
    } rpm_pstate_e;

    typedef enum logic [4:0] {
        BP_IDLE = 5'h01,
        BP_ADDR = 5'h02,
        BP_PTR = 5'h04,
        BP_WR = 5'h08,
        BP_RD = 5'h10
    } rpm_bphase_e;

endpackage : rpm_pkg

// [rpm_top.sv]
// Power-state, hot-plug and configuration register control of a video-link retimer.
// Assumes the configuration bus pins and all other inputs except enable_pin, which is synchronised here, are synchronous to clk.
`timescale 1ns/1ps
module rpm_top
    import rpm_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic enable_pin,
    input wire logic sink_hotplug_in,
    output logic source_hotplug_out,
    input wire logic signal_detect,
    input wire logic rate_high,
    input wire logic [NUM_STRAPS-1:0] strap_hi_sense,
    input wire logic [NUM_STRAPS-1:0] strap_lo_sense,
    input wire logic config_bus_clock_pin,
    input wire logic config_bus_data_pin_in,
    output logic config_bus_data_pin_out,
    output logic config_bus_data_pin_oe,
    output logic lane_inputs_enable,
    output logic lane_outputs_enable,
    output logic ddc_enable,
    output logic aux_channel_enable,
    output logic config_bus_enable,
    output logic clock_recovery_enable,
    output logic retimer_mode,
    output logic lane_swap,
    output logic equalizer_adaptive,
    output logic [1:0] output_termination_select,
    output logic termination_auto,
    output logic [1:0] edge_rate_select,
    output logic [1:0] tx_postcursor_level,
    output logic [2:0] data_swing_adjust,
    output logic [2:0] clock_swing_adjust,
    output logic clock_ratio_flag
);

    // ************************************************************
    // State of the block
    // ************************************************************
    typedef struct packed {
        logic en_s1;
        logic en_s2;
        logic en_q;
        rpm_pstate_e pstate;
        logic [7:0] reg_pd;
        logic ratio;
        logic [7:0] reg_ts;
        logic [7:0] reg_se;
        logic [NUM_STRAPS-1:0][1:0] strap;
        logic scl_q;
        logic sda_q;
        rpm_bphase_e bphase;
        logic [3:0] bitcnt;
        logic [7:0] shift;
        logic [7:0] ptr;
        logic nack;
        logic sda_oe;
        logic lanes_on;
        logic ddc_on;
        logic cdr_on;
        logic retimer;
    } rpm_state_s;

    localparam rpm_state_s ST_RESET = '{
        en_s1: 1'b0, en_s2: 1'b0, en_q: 1'b0, pstate: PS_OFF,
        reg_pd: RST_POWER_DOWN, ratio: 1'b0, reg_ts: RST_TERM_SLEW,
        reg_se: RST_SWING_EMPH, strap: '0, scl_q: 1'b1, sda_q: 1'b1,
        bphase: BP_IDLE, bitcnt: 4'h0, shift: 8'h00, ptr: 8'h00,
        nack: 1'b0, sda_oe: 1'b0, lanes_on: 1'b0, ddc_on: 1'b0,
        cdr_on: 1'b0, retimer: 1'b0
    };

    rpm_state_s st_reg;
    rpm_state_s st_next;
    logic [NUM_STRAPS-1:0][1:0] strap_lvl;
    logic cfg_clear;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic wr_pulse;
    logic [7:0] rd_data;

    // ************************************************************
    // Strap decode
    // ************************************************************
    // Each pad reports two comparators; neither tripping means the pin floats.
    for (genvar i = 0; i < NUM_STRAPS; i++) begin : g_strap
        assign strap_lvl[i] = strap_hi_sense[i] ? LVL_HIGH :
                              (strap_lo_sense[i] ? LVL_LOW : LVL_MID);
    end

    // Hot-plug is a pure wire so it follows the sink in every state, even in reset.
    assign source_hotplug_out = sink_hotplug_in;

    // Event decodes from the previous enable and bus samples.
    assign cfg_clear = st_reg.en_s2 & ~st_reg.en_q;
    assign scl_rise = config_bus_clock_pin & ~st_reg.scl_q;
    assign scl_fall = ~config_bus_clock_pin & st_reg.scl_q;
    assign bus_start = config_bus_clock_pin & st_reg.scl_q & st_reg.sda_q
                       & ~config_bus_data_pin_in;
    assign bus_stop = config_bus_clock_pin & st_reg.scl_q & ~st_reg.sda_q
                      & config_bus_data_pin_in;

    // Read mux; unmapped offsets read as zero.
    always_comb begin
        unique case (st_reg.ptr)
            OFS_POWER_DOWN: rd_data = st_reg.reg_pd;
            OFS_STATUS: rd_data = {5'h00, st_reg.retimer, st_reg.ratio, st_reg.lanes_on};
            OFS_TERM_SLEW: rd_data = st_reg.reg_ts;
            OFS_SWING_EMPH: rd_data = st_reg.reg_se;
            default: rd_data = 8'h00;
        endcase
    end

    // ************************************************************
    // Next-state logic
    // ************************************************************
    // Bus slave, register file and power sequencing in one pass.
    always_comb begin
        st_next = st_reg;
        wr_pulse = 1'b0;
        st_next.en_s1 = enable_pin;
        st_next.en_s2 = st_reg.en_s1;
        st_next.en_q = st_reg.en_s2;
        st_next.scl_q = config_bus_clock_pin;
        st_next.sda_q = config_bus_data_pin_in;

        // Configuration bus slave: byte in, ack out, auto-incrementing pointer.
        if (bus_stop) begin
            st_next.bphase = BP_IDLE;
            st_next.sda_oe = 1'b0;
        end else if (bus_start) begin
            st_next.bphase = BP_ADDR;
            st_next.bitcnt = 4'hf; // The clock fall that ends the start rolls this to zero.
            st_next.sda_oe = 1'b0;
        end else if (st_reg.bphase != BP_IDLE) begin
            if (scl_rise) begin
                if (st_reg.bitcnt != 4'h8 && st_reg.bphase != BP_RD) begin
                    st_next.shift = {st_reg.shift[6:0], config_bus_data_pin_in};
                end else if (st_reg.bitcnt == 4'h8 && st_reg.bphase == BP_RD) begin
                    st_next.nack = config_bus_data_pin_in;
                end
            end else if (scl_fall) begin
                if (st_reg.bitcnt == 4'h7) begin
                    st_next.bitcnt = 4'h8;
                    unique case (st_reg.bphase)
                        BP_ADDR: begin
                            st_next.sda_oe = (st_reg.shift[7:1] == BUS_ADDR);
                            st_next.nack = st_reg.shift[0];
                            if (st_reg.shift[7:1] != BUS_ADDR) begin
                                st_next.bphase = BP_IDLE;
                            end
                        end
                        BP_PTR: begin
                            st_next.ptr = st_reg.shift;
                            st_next.sda_oe = 1'b1;
                        end
                        BP_WR: begin
                            wr_pulse = 1'b1;
                            st_next.ptr = st_reg.ptr + 8'h01;
                            st_next.sda_oe = 1'b1;
                        end
                        BP_RD: st_next.sda_oe = 1'b0;
                        default: st_next.bphase = BP_IDLE;
                    endcase
                end else if (st_reg.bitcnt == 4'h8) begin
                    st_next.bitcnt = 4'h0;
                    st_next.sda_oe = 1'b0;
                    // The address byte parks its read flag in nack.
                    if ((st_reg.bphase == BP_ADDR && st_reg.nack)
                        || (st_reg.bphase == BP_RD && !st_reg.nack)) begin
                        st_next.bphase = BP_RD;
                        st_next.sda_oe = ~rd_data[7];
                        st_next.shift = {rd_data[6:0], 1'b0};
                        st_next.ptr = st_reg.ptr + 8'h01;
                    end else if (st_reg.bphase == BP_RD) begin
                        st_next.bphase = BP_IDLE;
                    end else if (st_reg.bphase == BP_ADDR) begin
                        st_next.bphase = BP_PTR;
                    end else begin
                        st_next.bphase = BP_WR;
                    end
                end else begin
                    st_next.bitcnt = st_reg.bitcnt + 4'h1;
                    if (st_reg.bphase == BP_RD) begin
                        st_next.sda_oe = ~st_reg.shift[7];
                        st_next.shift = {st_reg.shift[6:0], 1'b0};
                    end
                end
            end
        end

        // A completed write byte lands in the register at the pointer.
        if (wr_pulse) begin
            unique case (st_reg.ptr)
                OFS_POWER_DOWN: st_next.reg_pd = st_reg.shift;
                OFS_STATUS: st_next.ratio = st_reg.shift[ST_RATIO_BIT];
                OFS_TERM_SLEW: st_next.reg_ts = st_reg.shift;
                OFS_SWING_EMPH: st_next.reg_se = st_reg.shift;
                default: st_next.reg_pd = st_reg.reg_pd;
            endcase
        end

        // Power state from enable, sink hot-plug and the soft power-down bit.
        if (!st_reg.en_s2 || cfg_clear) begin
            st_next.pstate = PS_OFF;
        end else if (!sink_hotplug_in) begin
            st_next.pstate = PS_NO_HPD;
        end else if (st_reg.reg_pd[PD_SOFT_PD_BIT]) begin
            st_next.pstate = PS_SOFT;
        end else begin
            st_next.pstate = PS_NORMAL;
        end

        // Leaving normal drops the ratio flag, unless a register write completes this cycle.
        if (st_reg.pstate == PS_NORMAL && st_next.pstate != PS_NORMAL && !wr_pulse) begin
            st_next.ratio = 1'b0;
        end

        // Enable low, and the cycle of its rising edge, hold every register at default.
        if (!st_reg.en_s2 || cfg_clear) begin
            st_next.reg_pd = RST_POWER_DOWN;
            st_next.reg_ts = RST_TERM_SLEW;
            st_next.reg_se = RST_SWING_EMPH;
            st_next.ratio = 1'b0;
            st_next.bphase = BP_IDLE;
            st_next.sda_oe = 1'b0;
            st_next.ptr = 8'h00;
        end

        // Straps are caught on the reset pulse that follows enable rising.
        if (cfg_clear) begin
            st_next.strap = strap_lvl;
        end

        st_next.lanes_on = (st_next.pstate == PS_NORMAL);
        st_next.ddc_on = (st_next.pstate == PS_NORMAL);
        st_next.cdr_on = (st_next.pstate == PS_NORMAL) && signal_detect;
        st_next.retimer = st_next.cdr_on && rate_high;
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Register control bit chooses between programmed fields and straps.
    logic reg_ctl;
    assign reg_ctl = st_reg.reg_pd[PD_REG_CTRL_BIT];
    assign config_bus_data_pin_out = 1'b0;
    assign config_bus_data_pin_oe = st_reg.sda_oe;
    assign lane_inputs_enable = st_reg.lanes_on;
    assign lane_outputs_enable = st_reg.cdr_on;
    assign ddc_enable = st_reg.ddc_on;
    assign aux_channel_enable = st_reg.ddc_on;
    assign config_bus_enable = st_reg.en_q;
    assign clock_recovery_enable = st_reg.cdr_on;
    assign retimer_mode = st_reg.retimer;
    assign lane_swap = st_reg.reg_pd[PD_LANE_SWAP_BIT];
    assign clock_ratio_flag = st_reg.ratio;
    assign equalizer_adaptive = (st_reg.strap[STRAP_EQ] != LVL_HIGH);
    assign output_termination_select = reg_ctl ? st_reg.reg_ts[TS_TERM_LSB +: 2]
                                               : st_reg.strap[STRAP_TERM];
    assign termination_auto = !reg_ctl && (st_reg.strap[STRAP_TERM] == LVL_MID);
    assign edge_rate_select = reg_ctl ? st_reg.reg_ts[TS_SLEW_LSB +: 2]
                            : (st_reg.strap[STRAP_SLEW] == LVL_MID ? SLEW_STRAP_MID
                                                                   : st_reg.strap[STRAP_SLEW]);
    // Strap emphasis: mid is 0 dB, low is -2 dB.
    assign tx_postcursor_level = reg_ctl ? st_reg.reg_se[SE_EMPH_LSB +: 2]
                               : (st_reg.strap[STRAP_EMPH] == LVL_MID ? EMPH_0DB
                               : (st_reg.strap[STRAP_EMPH] == LVL_LOW ? EMPH_M2DB
                                                                      : EMPH_HIGH));
    assign data_swing_adjust = st_reg.reg_se[SE_SWING_LSB +: 3];
    assign clock_swing_adjust = st_reg.reg_se[SE_SWING_LSB + 3 +: 3];

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_enable_steady_high;
        st_reg.en_s2 && st_reg.en_q;
    endsequence

    sequence s_enable_rise;
        st_reg.en_s2 && !st_reg.en_q;
    endsequence

    AST_OFF_QUIET: assert property (!st_reg.en_s2 |=> !lane_inputs_enable
        && !lane_outputs_enable && !ddc_enable && !config_bus_data_pin_oe)
        else $error("Enable low left a lane or bus active.");
    AST_RISE_DEFAULTS: assert property (s_enable_rise |=> st_reg.reg_pd == RST_POWER_DOWN
        && st_reg.reg_ts == RST_TERM_SLEW && st_reg.reg_se == RST_SWING_EMPH && !st_reg.ratio
        && !lane_inputs_enable)
        else $error("Enable rising edge did not restore defaults.");
    AST_RESET_PULSE_ONCE: assert property (s_enable_rise |=> !(st_reg.en_s2 && !st_reg.en_q))
        else $error("Reset pulse lasted more than one cycle.");
    AST_NO_HPD_PD: assert property (s_enable_steady_high and !sink_hotplug_in
        |=> !lane_inputs_enable && !ddc_enable && config_bus_enable)
        else $error("Hot-plug low did not hold power-down.");
    AST_SOFT_PD: assert property (s_enable_steady_high and sink_hotplug_in
        and st_reg.reg_pd[PD_SOFT_PD_BIT] |=> !lane_inputs_enable && config_bus_enable)
        else $error("Soft power-down bit ignored.");
    AST_HPD_PASS: assert property (source_hotplug_out == sink_hotplug_in)
        else $error("Source hot-plug differs from sink.");
    AST_CDR_GATED: assert property (clock_recovery_enable |-> $past(signal_detect)
        && lane_inputs_enable)
        else $error("Clock recovery enabled without signal detect.");
    AST_RATIO_CLEAR: assert property ($fell(lane_inputs_enable) && !$past(wr_pulse)
        |-> !clock_ratio_flag)
        else $error("Clock-ratio flag survived power-down entry.");
    AST_NORMAL: assert property (s_enable_steady_high and sink_hotplug_in
        and !st_reg.reg_pd[PD_SOFT_PD_BIT] |=> lane_inputs_enable && ddc_enable
        && aux_channel_enable)
        else $error("Normal operation not entered.");
    AST_TERM_SLEW: assert property (reg_ctl |-> output_termination_select
        == st_reg.reg_ts[4:3] && edge_rate_select == st_reg.reg_ts[7:6])
        else $error("Termination or edge-rate field not applied.");
    AST_SWING_EMPH: assert property (reg_ctl |-> tx_postcursor_level
        == st_reg.reg_se[1:0] && {clock_swing_adjust, data_swing_adjust} == st_reg.reg_se[7:2])
        else $error("Swing or emphasis field not applied.");
    AST_STRAP_DEC: assert property (s_enable_rise |=> st_reg.strap
        == $past(strap_lvl))
        else $error("Strap levels not captured on reset pulse.");
    AST_STRAP_EMPH: assert property (!reg_ctl && st_reg.strap[STRAP_EMPH] == LVL_LOW
        |-> tx_postcursor_level == EMPH_M2DB)
        else $error("Low emphasis strap not mapped to -2 dB.");
    AST_EQUALIZER_SELECT: assert property ((st_reg.strap[STRAP_EQ] == LVL_HIGH)
        |-> !equalizer_adaptive)
        else $error("Equaliser strap did not select fixed equalisation.");

endmodule : rpm_top

// [rpm_host.sv]
// Behavioural two-wire controller that programs the power mode block.
// Assumes a pull-up on the data wire; line is the resolved wire level.
`timescale 1ns/1ps
module rpm_host
    import rpm_pkg::*;
(
    input wire logic clk,
    input wire logic line,
    output logic scl = 1'b1,
    output logic sda = 1'b1
);
    // Three cycles per level keeps each bus phase above the two-cycle minimum.
    task automatic lv(input logic c, input logic d);
        scl <= c;
        sda <= d;
        repeat (3) @(posedge clk);
    endtask : lv

    // Eight data bits and the answer bit, MSB first; q[0] low means acknowledged.
    task automatic by(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            lv(1'b0, d[i]);
            lv(1'b1, d[i]);
            q[i] = line;
            lv(1'b0, d[i]);
        end
    endtask : by

    // Start, device address for writing, then the register pointer.
    task automatic sp(input logic [7:0] p);
        logic [8:0] q;
        lv(1'b1, 1'b1);
        lv(1'b1, 1'b0);
        by({BUS_ADDR, 2'b01}, q);
        by({p, 1'b1}, q);
    endtask : sp

    // One register write; ak is high when the data byte was acknowledged.
    task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic ak);
        logic [8:0] q;
        sp(p);
        by({d, 1'b1}, q);
        lv(1'b0, 1'b0);
        lv(1'b1, 1'b0);
        lv(1'b1, 1'b1);
        ak = !q[0];
    endtask : wr

    // Pointer write, repeated start, one byte read and closed with a refusal.
    task automatic rd(input logic [7:0] p, output logic [7:0] d);
        logic [8:0] q;
        sp(p);
        lv(1'b1, 1'b1);
        lv(1'b1, 1'b0);
        by({BUS_ADDR, 2'b11}, q);
        by(9'h1ff, q);
        lv(1'b0, 1'b0);
        lv(1'b1, 1'b0);
        lv(1'b1, 1'b1);
        d = q[8:1];
    endtask : rd
endmodule : rpm_host

// [rpm_top_tb.sv]
// Self-checking bench for the power mode block, driven through the host model.
// Assumes a pull-up on the configuration data wire.
`timescale 1ns/1ps
module rpm_top_tb
    import rpm_pkg::*;
;
    logic clk = 1'b0, reset = 1'b1, en = 1'b0, hp = 1'b1, sd = 1'b1, rh = 1'b0;
    logic [3:0] shi = 4'h8, slo = 4'h1;
    logic scl, sda, oe, dout, ak, source_hotplug_out, lane_inputs_enable, lane_outputs_enable;
    logic ddc_enable, aux_channel_enable, config_bus_enable, clock_recovery_enable;
    logic retimer_mode, lane_swap, equalizer_adaptive, termination_auto, clock_ratio_flag;
    logic [1:0] output_termination_select, edge_rate_select, tx_postcursor_level;
    logic [2:0] data_swing_adjust, clock_swing_adjust;
    logic [7:0] q;
    int num_errors = 0, compares = 0;
    wire logic line = sda & (~oe | dout);
    wire logic [7:0] st = {lane_inputs_enable, lane_outputs_enable, ddc_enable,
        aux_channel_enable, config_bus_enable, clock_recovery_enable, retimer_mode,
        clock_ratio_flag};
    wire logic [7:0] cf = {output_termination_select, edge_rate_select, tx_postcursor_level,
        termination_auto, equalizer_adaptive};

    rpm_top dut (.clk, .reset, .enable_pin(en), .sink_hotplug_in(hp), .signal_detect(sd),
        .rate_high(rh), .strap_hi_sense(shi), .strap_lo_sense(slo), .config_bus_clock_pin(scl),
        .config_bus_data_pin_in(line), .config_bus_data_pin_out(dout), .config_bus_data_pin_oe(oe),
        .source_hotplug_out, .lane_inputs_enable, .lane_outputs_enable, .ddc_enable,
        .aux_channel_enable, .config_bus_enable, .clock_recovery_enable, .retimer_mode,
        .lane_swap, .equalizer_adaptive, .output_termination_select, .termination_auto,
        .edge_rate_select, .tx_postcursor_level, .data_swing_adjust, .clock_swing_adjust,
        .clock_ratio_flag);
    rpm_host h (.clk, .line, .scl, .sda);

    // The 10 MHz clock.
    initial begin
        forever #50 clk = ~clk;
    end

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk

    // Enables follow the synchronised enable pin within a few cycles.
    task automatic stl;
        repeat (8) @(posedge clk);
        chk({7'h0, source_hotplug_out}, {7'h0, hp});
    endtask : stl

    task automatic complete_run;
        if (num_errors == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    // Main sequence; first straps are emphasis low, equaliser high, the rest floating.
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        stl;
        chk(st, 8'h00);
        h.wr(8'h09, 8'h03, ak);
        chk({7'h0, ak}, 8'h00);
        hp <= 1'b0;
        en <= 1'b1;
        stl;
        chk(st, 8'h08);
        chk(cf, 8'h66);
        hp <= 1'b1;
        stl;
        chk(st, 8'hfc);
        rh <= 1'b1;
        stl;
        chk(st, 8'hfe);
        sd <= 1'b0;
        stl;
        chk(st, 8'hb8);
        sd <= 1'b1;
        h.wr(8'h09, 8'h03, ak);
        h.wr(8'h0b, 8'hd8, ak);
        h.wr(8'h0c, 8'hfd, ak);
        stl;
        chk(cf, 8'hf4);
        chk({data_swing_adjust, clock_swing_adjust, lane_swap, ak}, 8'hff);
        h.rd(8'h0b, q);
        chk(q, 8'hd8);
        h.wr(8'h0a, 8'h02, ak);
        stl;
        chk(st, 8'hff);
        h.wr(8'h09, 8'h0b, ak);
        stl;
        chk(st, 8'h08);
        h.rd(8'h09, q);
        chk(q, 8'h0b);
        h.wr(8'h09, 8'h03, ak);
        stl;
        chk(st, 8'hfe);
        shi <= 4'h0;
        slo <= 4'h0;
        en <= 1'b0;
        stl;
        chk(st, 8'h00);
        en <= 1'b1;
        stl;
        h.rd(8'h0b, q);
        chk(q, 8'h00);
        chk(cf, 8'h63);
        h.wr(8'h0b, 8'hd8, ak);
        chk({7'h0, ak}, 8'h01);
        rh <= 1'b0;
        h.wr(8'h09, 8'h01, ak);
        h.wr(8'h0b, 8'h80, ak);
        stl;
        chk(cf, 8'h21);
        chk(st, 8'hfc);
        complete_run;
    end

    // The sequence needs about 3700 cycles; this cuts a hang short.
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        complete_run;
    end
endmodule : rpm_top_tb
